// file: hw/trace_ctl_pkg.sv
package trace_ctl_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SEL_W  = 3;

	// Register byte offsets
	localparam logic [11:0] OFS_PROGRAMMING_CONTROL   = 12'h004;
	localparam logic [11:0] OFS_CORE_SELECT_CONTROL   = 12'h008;
	localparam logic [11:0] OFS_UNIT_STATUS           = 12'h00C;
	localparam logic [11:0] OFS_INTEGRATION_MODE_CTRL = 12'hF00;
	localparam logic [11:0] OFS_CLAIM_TAG_SET         = 12'hFA0;
	localparam logic [11:0] OFS_CLAIM_TAG_CLEAR       = 12'hFA4;
	localparam logic [11:0] OFS_DEVICE_AFFINITY       = 12'hFA8;
	localparam logic [11:0] OFS_SOFTWARE_LOCK_ACCESS  = 12'hFB0;
	localparam logic [11:0] OFS_SOFTWARE_LOCK_STATUS  = 12'hFB4;
	localparam logic [11:0] OFS_AUTHENTICATION_STATUS = 12'hFB8;
	localparam logic [11:0] OFS_DEVICE_ARCHITECTURE   = 12'hFBC;
	localparam logic [11:0] OFS_DEVICE_CONFIG_ID      = 12'hFC8;
	localparam logic [11:0] OFS_DEVICE_TYPE           = 12'hFCC;
	localparam logic [11:0] OFS_PERIPHERAL_ID_FIRST   = 12'hFD0;
	localparam logic [11:0] OFS_COMPONENT_ID_LAST     = 12'hFFC;

	// Field positions
	localparam int unsigned PRG_EN_BIT      = 0;
	localparam int unsigned STAT_IDLE_BIT   = 0;
	localparam int unsigned STAT_STABLE_BIT = 1;
	localparam int unsigned SEL_LSB         = 0;

	// Reset values
	localparam logic [31:0] RST_PROGRAMMING_CONTROL = 32'h0000_0000;
	localparam logic [31:0] RST_CORE_SELECT_CONTROL = 32'h0000_0000;

	typedef struct packed {
		logic              sel;
		logic              enable;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} apb_req_s;

endpackage

// file: hw/trace_unit_control_status.sv
`timescale 1ns/1ps
module trace_unit_control_status (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire trace_ctl_pkg::apb_req_s       apbReq,
	output logic [trace_ctl_pkg::DATA_W-1:0]   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          core_activity_in,
	input  wire logic                          traceDrained,
	output logic                               trace_interface_enable_out,
	output logic [trace_ctl_pkg::SEL_W-1:0]    core_trace_select,
	output logic                               traceClockEnable
);

	typedef enum logic [3:0] {
		BUS_IDLE   = 4'h1,
		BUS_SETUP  = 4'h2,
		BUS_ACCESS = 4'h4,
		BUS_ANSWER = 4'h8
	} busPhase_e;

	// Register state
	busPhase_e                        busPhase_ff;
	busPhase_e                        nxt_busPhase;
	logic                             progEnable_ff;
	logic                             nxt_progEnable;
	logic [trace_ctl_pkg::SEL_W-1:0]  coreSel_ff;
	logic [trace_ctl_pkg::SEL_W-1:0]  nxt_coreSel;
	logic                             activitySync1_ff;
	logic                             activitySync2_ff;

	// Decode
	logic                             accessPhase;
	logic                             wrStrobe;
	logic                             rdStrobe;
	logic                             hitProgCtl;
	logic                             hitCoreSel;
	logic                             hitStatus;
	logic                             hitFixed;
	logic                             hitIdBlock;
	logic                             addrMapped;

	// Read path
	logic                             unitIdle;
	logic                             modelStable;
	logic [trace_ctl_pkg::DATA_W-1:0] progCtlView;
	logic [trace_ctl_pkg::DATA_W-1:0] coreSelView;
	logic [trace_ctl_pkg::DATA_W-1:0] statusView;
	logic [trace_ctl_pkg::DATA_W-1:0] nxt_prdata;
	logic                             nxt_pready;
	logic                             nxt_pslverr;

	// Clock request
	logic                             busDemand;
	logic                             drainDemand;
	logic                             activeDemand;
	logic                             nxt_traceClockEnable;

	////////////////////////////////////////////////////////////////////////////
	// Bus phase

	// Access taken once, answer one cycle later
	assign accessPhase = apbReq.sel && apbReq.enable && (busPhase_ff != BUS_ANSWER);
	assign wrStrobe    = accessPhase && apbReq.write;
	assign rdStrobe    = accessPhase && !apbReq.write;

	always_comb begin
		nxt_busPhase = BUS_IDLE;
		case (busPhase_ff)
			BUS_IDLE, BUS_SETUP, BUS_ACCESS: begin
				if (accessPhase) begin
					nxt_busPhase = BUS_ANSWER;
				end else if (apbReq.sel) begin
					nxt_busPhase = BUS_SETUP;
				end
			end
			BUS_ANSWER: begin
				if (apbReq.sel && apbReq.enable) begin
					nxt_busPhase = BUS_ACCESS;
				end else if (apbReq.sel) begin
					nxt_busPhase = BUS_SETUP;
				end
			end
			default: begin
				nxt_busPhase = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busPhase_ff <= BUS_IDLE;
		end else begin
			busPhase_ff <= nxt_busPhase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	assign hitProgCtl = apbReq.addr == trace_ctl_pkg::OFS_PROGRAMMING_CONTROL;
	assign hitCoreSel = apbReq.addr == trace_ctl_pkg::OFS_CORE_SELECT_CONTROL;
	assign hitStatus  = apbReq.addr == trace_ctl_pkg::OFS_UNIT_STATUS;
	assign hitIdBlock = (apbReq.addr >= trace_ctl_pkg::OFS_PERIPHERAL_ID_FIRST)
		&& (apbReq.addr[1:0] == 2'h0);

	// Mapped but without state
	always_comb begin
		case (apbReq.addr)
			trace_ctl_pkg::OFS_INTEGRATION_MODE_CTRL,
			trace_ctl_pkg::OFS_CLAIM_TAG_SET,
			trace_ctl_pkg::OFS_CLAIM_TAG_CLEAR,
			trace_ctl_pkg::OFS_DEVICE_AFFINITY,
			trace_ctl_pkg::OFS_SOFTWARE_LOCK_ACCESS,
			trace_ctl_pkg::OFS_SOFTWARE_LOCK_STATUS,
			trace_ctl_pkg::OFS_AUTHENTICATION_STATUS,
			trace_ctl_pkg::OFS_DEVICE_ARCHITECTURE,
			trace_ctl_pkg::OFS_DEVICE_CONFIG_ID,
			trace_ctl_pkg::OFS_DEVICE_TYPE: begin
				hitFixed = 1'h1;
			end
			default: begin
				hitFixed = 1'h0;
			end
		endcase
	end

	assign addrMapped = hitProgCtl || hitCoreSel || hitStatus
		|| hitFixed || hitIdBlock;

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_comb begin
		nxt_progEnable = progEnable_ff;
		if (wrStrobe && hitProgCtl) begin
			nxt_progEnable = apbReq.wdata[trace_ctl_pkg::PRG_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			progEnable_ff <= trace_ctl_pkg::RST_PROGRAMMING_CONTROL[trace_ctl_pkg::PRG_EN_BIT];
		end else begin
			progEnable_ff <= nxt_progEnable;
		end
	end

	always_comb begin
		nxt_coreSel = coreSel_ff;
		if (wrStrobe && hitCoreSel && progEnable_ff) begin
			nxt_coreSel = apbReq.wdata[trace_ctl_pkg::SEL_LSB +: trace_ctl_pkg::SEL_W];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			coreSel_ff <= trace_ctl_pkg::RST_CORE_SELECT_CONTROL[trace_ctl_pkg::SEL_W-1:0];
		end else begin
			coreSel_ff <= nxt_coreSel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core activity synchroniser

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			activitySync1_ff <= 1'h0;
			activitySync2_ff <= 1'h0;
		end else begin
			activitySync1_ff <= core_activity_in;
			activitySync2_ff <= activitySync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status and read data

	assign unitIdle    = !progEnable_ff && traceDrained;
	assign modelStable = unitIdle;

	always_comb begin
		progCtlView                            = '0;
		progCtlView[trace_ctl_pkg::PRG_EN_BIT] = progEnable_ff;
	end

	always_comb begin
		coreSelView                                                 = '0;
		coreSelView[trace_ctl_pkg::SEL_LSB +: trace_ctl_pkg::SEL_W] = coreSel_ff;
	end

	always_comb begin
		statusView                                 = '0;
		statusView[trace_ctl_pkg::STAT_IDLE_BIT]   = unitIdle;
		statusView[trace_ctl_pkg::STAT_STABLE_BIT] = modelStable;
	end

	for (genvar b = 0; b < int'(trace_ctl_pkg::DATA_W); b++) begin : g_rdBit
		assign nxt_prdata[b] = (hitProgCtl && progCtlView[b])
			|| (hitCoreSel && coreSelView[b])
			|| (hitStatus && statusView[b]);
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus answer

	always_comb begin
		nxt_pready  = accessPhase;
		nxt_pslverr = accessPhase && !addrMapped;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'h0;
		end else begin
			pready <= nxt_pready;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'h0;
		end else begin
			pslverr <= nxt_pslverr;
		end
	end

	// Read data stands one cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (rdStrobe) begin
			prdata <= nxt_prdata;
		end else begin
			prdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs to the trace path

	// interface enable follows the enable bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trace_interface_enable_out <= 1'h0;
		end else begin
			trace_interface_enable_out <= progEnable_ff;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_trace_select <= '0;
		end else begin
			core_trace_select <= coreSel_ff;
		end
	end

	// bus access (enable bit clear), core activity (enable bit set) or drain wakes clocks
	assign busDemand    = apbReq.sel;
	assign drainDemand  = !traceDrained;
	assign activeDemand = activitySync2_ff;

	always_comb begin
		if (progEnable_ff) begin
			nxt_traceClockEnable = activeDemand || drainDemand;
		end else begin
			// run only for access or drain
			nxt_traceClockEnable = busDemand || drainDemand;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			traceClockEnable <= 1'h0;
		end else begin
			traceClockEnable <= nxt_traceClockEnable;
		end
	end

endmodule

// file: testbench/trace_unit_control_status_assertions.sv
`timescale 1ns/1ps
module trace_unit_control_status_chk (
	input wire logic                    clk,
	input wire logic                    arst_n,
	input wire trace_ctl_pkg::apb_req_s apbReq,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    core_activity_in,
	input wire logic                    traceDrained,
	input wire logic                    trace_interface_enable_out,
	input wire logic [2:0]              core_trace_select,
	input wire logic                    traceClockEnable
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic        take;
	logic        wr;
	logic        stRd;
	logic [11:0] adr;
	assign adr = apbReq.addr;
	assign take = apbReq.sel && apbReq.enable && !pready;
	assign wr = take && apbReq.write;
	assign stRd = take && !apbReq.write && adr == 12'h00C;
	property p_answer;
		take && adr inside {12'h004, 12'h008, 12'h00C} |=> pready && !pslverr;
	endproperty
	a_answer: assert property (p_answer) else $error("access not answered");
	property p_idle;
		stRd |=> prdata[0] == (!trace_interface_enable_out && $past(traceDrained));
	endproperty
	a_idle: assert property (p_idle) else $error("idle bit wrong");
	property p_stable;
		stRd |=> prdata[1] == (!trace_interface_enable_out && $past(traceDrained));
	endproperty
	a_stable: assert property (p_stable) else $error("stable bit wrong");
	property p_pin;
		wr && adr == 12'h004 |-> ##2
			trace_interface_enable_out == $past(apbReq.wdata[0], 2);
	endproperty
	a_pin: assert property (p_pin) else $error("enable pin wrong");
	property p_sel;
		wr && adr == 12'h008 ##1 trace_interface_enable_out
			|=> core_trace_select == $past(apbReq.wdata[2:0], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("select wrong");
	property p_lock;
		wr && adr == 12'h008 ##1 !trace_interface_enable_out |=> $stable(core_trace_select);
	endproperty
	a_lock: assert property (p_lock) else $error("select written");
	property p_gate;
		traceDrained && !apbReq.sel ##1 !trace_interface_enable_out |-> !traceClockEnable;
	endproperty
	a_gate: assert property (p_gate) else $error("clock not gated");
	property p_run;
		core_activity_in [*3] ##1 trace_interface_enable_out |-> traceClockEnable;
	endproperty
	a_run: assert property (p_run) else $error("clock stopped");
endmodule
bind trace_unit_control_status trace_unit_control_status_chk i_trace_unit_control_status_chk (
	.clk(clk), .arst_n(arst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .core_activity_in(core_activity_in), .traceDrained(traceDrained),
	.trace_interface_enable_out(trace_interface_enable_out),
	.core_trace_select(core_trace_select), .traceClockEnable(traceClockEnable)
);

// file: testbench/trace_source_model.sv
`timescale 1ns/1ps
module trace_source_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       traceClockEnable,
	input  wire logic [3:0] genBeats,
	input  wire logic       coreBusy,
	output logic            core_activity_in,
	output logic            traceDrained
);
	logic [3:0] pend_ff;
	assign core_activity_in = coreBusy;
	assign traceDrained = pend_ff == 4'h0;
	// Pending trace drains only while clocked
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			pend_ff <= 4'h0;
		else if (genBeats != 4'h0)
			pend_ff <= genBeats;
		else if (traceClockEnable && !traceDrained)
			pend_ff <= pend_ff - 4'h1;
	end
endmodule

// file: testbench/trace_unit_control_status_test.sv
`timescale 1ns/1ps
module trace_unit_control_status_test;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic coreBusy = 1'b0;
	logic [3:0] genBeats = 4'h0;
	trace_ctl_pkg::apb_req_s apbReq = '0;
	logic [31:0] prdata, rd;
	logic [2:0] core_trace_select;
	logic pready, pslverr, core_activity_in, traceDrained, trace_interface_enable_out;
	logic traceClockEnable, er;
	int err_count = 0;
	int num_checks = 0;
	always #2.5 clk = ~clk;
	trace_unit_control_status i_trace_unit_control_status (
		.clk(clk), .arst_n(arst_n), .apbReq(apbReq), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_activity_in(core_activity_in), .traceDrained(traceDrained),
		.trace_interface_enable_out(trace_interface_enable_out),
		.core_trace_select(core_trace_select), .traceClockEnable(traceClockEnable)
	);
	trace_source_model i_trace_source_model (
		.clk(clk), .arst_n(arst_n), .traceClockEnable(traceClockEnable), .genBeats(genBeats),
		.coreBusy(coreBusy), .core_activity_in(core_activity_in), .traceDrained(traceDrained)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int n = 0;
		@(posedge clk);
		apbReq <= '{1'b1, 1'b0, w, ad, wd};
		@(posedge clk);
		apbReq.enable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 9);
		chk(pready, 32'h1);
		rd = prdata;
		er = pslverr;
		apbReq <= '0;
	endtask
	task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
		chk(er, 32'h0);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		test_done();
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rdchk(12'h004, 32'h0);
		rdchk(12'h008, 32'h0);
		chk(core_trace_select, 32'h0);
		apb(1'b1, 12'h008, 32'h5);
		rdchk(12'h008, 32'h0);
		rdchk(12'h00C, 32'h3);
		genBeats <= 4'hF;
		@(posedge clk);
		genBeats <= 4'h0;
		rdchk(12'h00C, 32'h0);
		repeat (16) @(posedge clk);
		chk(traceClockEnable, 32'h0);
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		rdchk(12'h004, 32'h1);
		chk(trace_interface_enable_out, 32'h1);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h008, 32'hFFFFFFF8 | i);
			@(posedge clk);
			chk(core_trace_select, i);
		end
		rdchk(12'h008, 32'h7);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		rdchk(12'h00C, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 32'h1);
		coreBusy <= 1'b1;
		repeat (5) @(posedge clk);
		chk(traceClockEnable, 32'h1);
		coreBusy <= 1'b0;
		repeat (5) @(posedge clk);
		chk(traceClockEnable, 32'h0);
		apb(1'b1, 12'h004, 32'h0);
		@(posedge clk);
		chk(trace_interface_enable_out, 32'h0);
		test_done();
	end
endmodule
